//--- logic/cal_ctrl.sv
/*
  Calibration control: configuration registers, clear/foreground
  sequencer, background stop tracking, status and interrupt.
  Assumes a single AHB-Lite master, 32-bit word accesses only, and
  the converter core running on the same clock.
*/
`timescale 1ns/100ps

// Summary of operation
// - FG bit set: clear values, run foreground
// - FG bit clear: clear values, skip foreground
// - Bit 1 enables background calibration
// - Background offset needs background enable
// - Foreground offset needs foreground enable
// - Parking field picks disabled sub-converter while background is off
// - Second substitutes parked first or third
// - Offset averaging depth at bits 6:4
// - Linearity averaging depth at bits 2:0
// - Stopped reads 1 when background halted
// - Stopped clears when calibration resumes
// - Background off: stopped set after foreground
// - Done high after foreground completes/skipped
// - Calibration runs only with master enable
module cal_ctrl #(
  parameter int FG_SCALE = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic cal_running,
  output logic foreground_active,
  output logic background_active,
  output logic foreground_offset_active,
  output logic background_offset_active,
  output logic [2:0] sub_enable,
  output logic [1:0] second_stands_for,
  output logic [2:0] offset_averaging_depth,
  output logic [2:0] linearity_averaging_depth
);

  // fg_len is 16 bits and depth 7 shifts it by seven, so scale could reach 31; the check stops it at 16
  if (FG_SCALE < 1 || FG_SCALE > 16) begin : g_bad_scale
    $error("FG_SCALE out of range");
  end

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_CLEAR = 2'b01,
    ST_FG = 2'b10,
    ST_IDLE = 2'b11
  } seq_e;

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic wr_q, rd_q;
  logic [7:0] idx_q;
  logic ok_addr;
  assign ok_addr = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h0);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel && htrans[1] && hwrite && ok_addr;
      rd_q <= hsel && htrans[1] && !hwrite && ok_addr;
      idx_q <= haddr[9:2];
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] main_q, park_q, avg_q, master_q, mask_q, ctrl_q;
  logic [7:0] wdat;
  assign wdat = hwdata[7:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      main_q <= cal_ctrl_pkg::MAIN_RST;
      park_q <= cal_ctrl_pkg::PARK_RST;
      avg_q <= cal_ctrl_pkg::AVG_RST;
      master_q <= cal_ctrl_pkg::MASTER_RST;
      mask_q <= 8'h00;
      ctrl_q <= 8'h00;
    end else if (wr_q) begin
      case (idx_q)
        // Reserved bits are never stored, so they read zero
        cal_ctrl_pkg::IDX_CFG_MAIN:
          main_q <= wdat & cal_ctrl_pkg::MAIN_MASK;
        cal_ctrl_pkg::IDX_CFG_PARK:
          park_q <= wdat & cal_ctrl_pkg::PARK_MASK;
        cal_ctrl_pkg::IDX_AVG:
          avg_q <= wdat & cal_ctrl_pkg::AVG_MASK;
        cal_ctrl_pkg::IDX_MASTER: master_q <= wdat & 8'h01;
        cal_ctrl_pkg::IDX_IRQ_MASK: mask_q <= wdat & 8'h03;
        cal_ctrl_pkg::IDX_CTRL: ctrl_q <= wdat & 8'h01;
        default: ;
      endcase
    end
  end

  logic master_en, fg_en, bg_en;
  assign master_en = master_q[0];
  assign fg_en = main_q[cal_ctrl_pkg::FG_BIT];
  assign bg_en = main_q[cal_ctrl_pkg::BG_BIT];

  // ----------------------------------------------------------------
  // Clear / foreground sequencer
  // ----------------------------------------------------------------
  // Foreground length grows with linearity averaging depth, a stand-in
  // for the core's real run time.
  seq_e seq_q;
  logic [15:0] cnt_q;
  logic [15:0] fg_len;
  assign fg_len = 16'(cal_ctrl_pkg::FG_BASE_CYCLES * FG_SCALE)
                  << avg_q[2:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_q <= ST_HOLD;
      cnt_q <= 16'h0000;
    end else if (!master_en) begin
      seq_q <= ST_HOLD;
      cnt_q <= 16'h0000;
    end else begin
      case (seq_q)
        ST_HOLD: begin
          seq_q <= ST_CLEAR;
          cnt_q <= 16'(cal_ctrl_pkg::CLEAR_CYCLES - 1);
        end
        ST_CLEAR: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (fg_en) begin
            seq_q <= ST_FG;
            cnt_q <= fg_len - 16'h0001;
          end else begin
            seq_q <= ST_IDLE;
          end
        end
        ST_FG: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            seq_q <= ST_IDLE;
          end
        end
        ST_IDLE: cnt_q <= 16'h0000;
        default: seq_q <= ST_HOLD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  logic done_q, stop_q;
  logic bg_run, stop_req;
  assign stop_req = ctrl_q[cal_ctrl_pkg::PHASE_BIT];
  assign bg_run = (seq_q == ST_IDLE) && bg_en && !stop_req;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= master_en && (seq_q == ST_IDLE);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stop_q <= 1'b0;
    end else if (!master_en || seq_q != ST_IDLE) begin
      stop_q <= 1'b0;
    end else if (!bg_en) begin
      stop_q <= 1'b1;
    end else begin
      stop_q <= stop_req;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt: sticky on rising done/stopped, write one to clear
  // ----------------------------------------------------------------
  logic [1:0] irq_q, prev_q, rise, wclr;
  assign rise = {stop_q, done_q} & ~prev_q;
  assign wclr = (wr_q && idx_q == cal_ctrl_pkg::IDX_IRQ_STAT) ?
                wdat[1:0] : 2'b00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 2'b00;
      irq_q <= 2'b00;
      irq <= 1'b0;
    end else begin
      prev_q <= {stop_q, done_q};
      // Set wins over a simultaneous clear
      irq_q <= (irq_q & ~wclr) | rise;
      irq <= |(((irq_q & ~wclr) | rise) & mask_q[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Core-facing controls, all registered
  // ----------------------------------------------------------------
  logic [1:0] park;
  assign park = park_q[1:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cal_running <= 1'b0;
      foreground_active <= 1'b0;
      background_active <= 1'b0;
      foreground_offset_active <= 1'b0;
      background_offset_active <= 1'b0;
      sub_enable <= 3'b000;
      second_stands_for <= cal_ctrl_pkg::SUB_SECOND;
      offset_averaging_depth <= 3'h0;
      linearity_averaging_depth <= 3'h0;
    end else begin
      cal_running <= master_en && seq_q != ST_HOLD;
      foreground_active <= seq_q == ST_FG;
      background_active <= master_en && bg_run;
      foreground_offset_active <= seq_q == ST_FG &&
                                  main_q[cal_ctrl_pkg::FGOS_BIT];
      background_offset_active <= master_en && bg_run &&
                                  main_q[cal_ctrl_pkg::BGOS_BIT];
      offset_averaging_depth <= avg_q[6:4];
      linearity_averaging_depth <= avg_q[2:0];
      if (bg_en || park == cal_ctrl_pkg::PARK_RSVD) begin
        // Reserved parking code leaves all three running
        sub_enable <= 3'b111;
        second_stands_for <= cal_ctrl_pkg::SUB_SECOND;
      end else begin
        sub_enable <= ~(3'b001 << park);
        // Parking the second needs no stand-in
        second_stands_for <= (park == cal_ctrl_pkg::SUB_SECOND) ?
                             cal_ctrl_pkg::SUB_SECOND : park;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data; status writes fall in the default branch and vanish
  // ----------------------------------------------------------------
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    case (idx_q)
      cal_ctrl_pkg::IDX_CFG_MAIN: rmux = main_q;
      cal_ctrl_pkg::IDX_CFG_PARK: rmux = park_q;
      cal_ctrl_pkg::IDX_AVG: rmux = avg_q;
      cal_ctrl_pkg::IDX_STATUS: rmux = {6'h00, stop_q, done_q};
      cal_ctrl_pkg::IDX_MASTER: rmux = master_q;
      cal_ctrl_pkg::IDX_IRQ_STAT: rmux = {6'h00, irq_q};
      cal_ctrl_pkg::IDX_IRQ_MASK: rmux = mask_q;
      cal_ctrl_pkg::IDX_CTRL: rmux = ctrl_q;
      default: rmux = 8'h00;
    endcase
  end

  assign hrdata = {24'h000000, rd_q ? rmux : 8'h00};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_skip_fg;
    @(posedge clk) disable iff (!nrst)
    (seq_q == ST_CLEAR && cnt_q == 16'h0 && master_en && !fg_en)
      |=> seq_q == ST_IDLE;
  endproperty
  a_skip_fg: assert property (p_skip_fg) else $error("skip failed");

  property p_run_fg;
    @(posedge clk) disable iff (!nrst)
    (seq_q == ST_CLEAR && cnt_q == 16'h0 && master_en && fg_en)
      |=> seq_q == ST_FG;
  endproperty
  a_run_fg: assert property (p_run_fg) else $error("fg not run");

  property p_hold;
    @(posedge clk) disable iff (!nrst)
    !master_en |=> seq_q == ST_HOLD ##1 !cal_running;
  endproperty
  a_hold: assert property (p_hold) else $error("hold failed");

  property p_done;
    @(posedge clk) disable iff (!nrst)
    (master_en && seq_q == ST_IDLE) [*2] |-> done_q;
  endproperty
  a_done: assert property (p_done) else $error("done low");

  property p_stop_fg;
    @(posedge clk) disable iff (!nrst)
    done_q && $stable(main_q) && !bg_en && master_en |=> stop_q;
  endproperty
  a_stop_fg: assert property (p_stop_fg) else $error("stop");

  property p_resume;
    @(posedge clk) disable iff (!nrst)
    (bg_en && seq_q == ST_IDLE && master_en && !stop_req) |=> !stop_q;
  endproperty
  a_resume: assert property (p_resume) else $error("resume");

  property p_bgos;
    @(posedge clk) disable iff (!nrst)
    !bg_en |=> !background_offset_active;
  endproperty
  a_bgos: assert property (p_bgos) else $error("bg offset");

  property p_fgos;
    @(posedge clk) disable iff (!nrst)
    seq_q != ST_FG |=> !foreground_offset_active;
  endproperty
  a_fgos: assert property (p_fgos) else $error("fg offset");

  property p_park;
    @(posedge clk) disable iff (!nrst)
    (!bg_en && park == cal_ctrl_pkg::SUB_THIRD)
      |=> !sub_enable[2] && second_stands_for == cal_ctrl_pkg::SUB_THIRD;
  endproperty
  a_park: assert property (p_park) else $error("park");

  property p_status_ro;
    @(posedge clk) disable iff (!nrst)
    (wr_q && idx_q == cal_ctrl_pkg::IDX_STATUS) |=> $stable(main_q);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("ro");

  property p_fgos_on;
    @(posedge clk) disable iff (!nrst)
    (seq_q == ST_FG && main_q[cal_ctrl_pkg::FGOS_BIT])
      |=> foreground_offset_active;
  endproperty
  a_fgos_on: assert property (p_fgos_on) else $error("fgos off");

  property p_bgos_on;
    @(posedge clk) disable iff (!nrst)
    (master_en && bg_run && main_q[cal_ctrl_pkg::BGOS_BIT])
      |=> background_offset_active;
  endproperty
  a_bgos_on: assert property (p_bgos_on) else $error("bgos off");

  property p_park_first;
    @(posedge clk) disable iff (!nrst)
    (!bg_en && park == cal_ctrl_pkg::SUB_FIRST)
      |=> !sub_enable[0] && second_stands_for == cal_ctrl_pkg::SUB_FIRST;
  endproperty
  a_park_first: assert property (p_park_first) else $error("park0");

  property p_bg_all_on;
    @(posedge clk) disable iff (!nrst)
    bg_en |=> sub_enable == 3'h7;
  endproperty
  a_bg_all_on: assert property (p_bg_all_on) else $error("bg sub");

  property p_depths;
    @(posedge clk) disable iff (!nrst)
    1'h1 |=> offset_averaging_depth == $past(avg_q[6:4]) &&
             linearity_averaging_depth == $past(avg_q[2:0]);
  endproperty
  a_depths: assert property (p_depths) else $error("depths");

endmodule

//--- logic/cal_ctrl_pkg.sv
/*
  Constants for the converter calibration control block: register
  offsets, field positions, reset values and sequencing counts.
  Assumes a 32-bit AHB-Lite register bus, one word per register.
*/
package cal_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register indices as printed; byte address is four times these
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CFG_MAIN = 8'h62;
  localparam logic [7:0] IDX_CFG_PARK = 8'h64;
  localparam logic [7:0] IDX_AVG = 8'h68;
  localparam logic [7:0] IDX_STATUS = 8'h6A;
  localparam logic [7:0] IDX_MASTER = 8'h61;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
  localparam logic [7:0] IDX_CTRL = 8'h72;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FG_BIT = 0;
  localparam int BG_BIT = 1;
  localparam int FGOS_BIT = 2;
  localparam int BGOS_BIT = 3;
  localparam int PARK_LSB = 0;
  localparam int LIN_LSB = 0;
  localparam int OFS_LSB = 4;
  localparam int DONE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int PHASE_BIT = 0;

  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MAIN_MASK = 8'h0F;
  localparam logic [7:0] PARK_MASK = 8'h03;
  localparam logic [7:0] AVG_MASK = 8'h77;
  localparam logic [7:0] MAIN_RST = 8'h01;
  localparam logic [7:0] PARK_RST = 8'h02;
  localparam logic [7:0] AVG_RST = 8'h61;
  localparam logic [7:0] MASTER_RST = 8'h01;
  localparam logic [1:0] PARK_RSVD = 2'h3;

  // Sub-converter selections
  localparam logic [1:0] SUB_FIRST = 2'h0;
  localparam logic [1:0] SUB_SECOND = 2'h1;
  localparam logic [1:0] SUB_THIRD = 2'h2;

  // ----------------------------------------------------------------
  // Sequencing: clear, then foreground, in cycles of clk
  // ----------------------------------------------------------------
  localparam int CLEAR_CYCLES = 4;
  localparam int FG_BASE_CYCLES = 16;

  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_STOP = 1;

endpackage

//--- verif/adc_calibration_control_tb.sv
/*
  Self-checking bench for cal_ctrl: registers, sequencing, parking,
  background stop and interrupt.
  Assumes cal_ctrl is the only AHB-Lite slave and answers zero-wait.
*/
`timescale 1ns/100ps
module adc_calibration_control_tb;
  logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, stands;
  logic [2:0] hsize, sub_en, ofs_d, lin_d;
  logic run, fg_act, bg_act, fgo_act, bgo_act, fg_seen, fgo_seen;
  int bad_count, comparisons;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  cal_ctrl dut_u (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .cal_running(run),
    .foreground_active(fg_act), .background_active(bg_act),
    .foreground_offset_active(fgo_act),
    .background_offset_active(bgo_act), .sub_enable(sub_en),
    .second_stands_for(stands), .offset_averaging_depth(ofs_d),
    .linearity_averaging_depth(lin_d));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Sticky record of any foreground run since last cleared
  always @(posedge clk) begin
    if (fg_act === 1'b1) fg_seen <= 1'b1;
    if (fgo_act === 1'b1) fgo_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic xfer(input logic [7:0] idx, input logic wr_en,
                      input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr_en;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] t;
    xfer(idx, 1'b1, d, t);
  endtask

  task automatic rchk(input string name, input logic [7:0] idx,
                      input logic [31:0] exp);
    xfer(idx, 1'b0, 32'h0, rd);
    check(name, exp, rd);
  endtask

  // Bounded poll of the status bits picked by m
  task automatic poll(input logic [7:0] m, input logic [7:0] e);
    for (int i = 0; i < 300; i++) begin
      xfer(cal_ctrl_pkg::IDX_STATUS, 1'b0, 32'h0, rd);
      if ((rd[7:0] & m) === e) break;
    end
    check("status poll", {24'h0, e}, rd & {24'h0, m});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("status rst", cal_ctrl_pkg::IDX_STATUS, 32'h00);
    rchk("main rst", cal_ctrl_pkg::IDX_CFG_MAIN, 32'h01);
    rchk("park rst", cal_ctrl_pkg::IDX_CFG_PARK, 32'h02);
    rchk("avg rst", cal_ctrl_pkg::IDX_AVG, 32'h61);
    check("ofs depth", 32'h6, {29'h0, ofs_d});
    check("lin depth", 32'h1, {29'h0, lin_d});
    $display("test reset done");
  endtask

  task automatic t_done_irq();
    poll(8'h03, 8'h03);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(cal_ctrl_pkg::IDX_IRQ_MASK, 32'h03);
    repeat (3) @(posedge clk);
    check("irq on", 32'h1, {31'h0, irq});
    wr(cal_ctrl_pkg::IDX_IRQ_STAT, 32'h03);
    repeat (3) @(posedge clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    rchk("irq stat", cal_ctrl_pkg::IDX_IRQ_STAT, 32'h00);
    wr(cal_ctrl_pkg::IDX_IRQ_MASK, 32'h00);
    $display("test done_irq done");
  endtask

  task automatic t_regs();
    wr(cal_ctrl_pkg::IDX_STATUS, 32'h00);
    check("hresp", 32'h0, {31'h0, hresp});
    check("ready", 32'h1, {31'h0, hreadyout});
    rchk("status ro", cal_ctrl_pkg::IDX_STATUS, 32'h03);
    wr(cal_ctrl_pkg::IDX_CFG_MAIN, 32'hFF);
    rchk("main rsvd", cal_ctrl_pkg::IDX_CFG_MAIN, 32'h0F);
    wr(cal_ctrl_pkg::IDX_CFG_MAIN, 32'h01);
    wr(cal_ctrl_pkg::IDX_CFG_PARK, 32'hFF);
    rchk("park rsvd", cal_ctrl_pkg::IDX_CFG_PARK, 32'h03);
    wr(cal_ctrl_pkg::IDX_AVG, 32'hFF);
    rchk("avg rsvd", cal_ctrl_pkg::IDX_AVG, 32'h77);
    wr(cal_ctrl_pkg::IDX_AVG, 32'h35);
    repeat (3) @(posedge clk);
    check("ofs depth", 32'h3, {29'h0, ofs_d});
    check("lin depth", 32'h5, {29'h0, lin_d});
    rchk("unmapped", 8'h80, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_park();
    logic [2:0] exp;
    for (int p = 0; p < 4; p++) begin
      wr(cal_ctrl_pkg::IDX_CFG_PARK, p);
      repeat (3) @(posedge clk);
      case (p)
        0: exp = 3'h6;
        1: exp = 3'h5;
        2: exp = 3'h3;
        default: exp = 3'h7;
      endcase
      check("sub enable", {29'h0, exp}, {29'h0, sub_en});
      if (p < 3) check("stands", p, {30'h0, stands});
    end
    $display("test park done");
  endtask

  task automatic t_bg();
    wr(cal_ctrl_pkg::IDX_CFG_MAIN, 32'h03);
    repeat (3) @(posedge clk);
    check("bg sub", 32'h7, {29'h0, sub_en});
    check("bg act", 32'h1, {31'h0, bg_act});
    wr(cal_ctrl_pkg::IDX_CFG_MAIN, 32'h0B);
    repeat (3) @(posedge clk);
    check("bgos on", 32'h1, {31'h0, bgo_act});
    wr(cal_ctrl_pkg::IDX_CFG_MAIN, 32'h08);
    repeat (3) @(posedge clk);
    check("bgos alone", 32'h0, {31'h0, bgo_act});
    wr(cal_ctrl_pkg::IDX_CFG_MAIN, 32'h04);
    repeat (3) @(posedge clk);
    check("fgos alone", 32'h0, {31'h0, fgo_act});
    wr(cal_ctrl_pkg::IDX_CFG_MAIN, 32'h03);
    wr(cal_ctrl_pkg::IDX_CTRL, 32'h01);
    poll(8'h02, 8'h02);
    check("bg halted", 32'h0, {31'h0, bg_act});
    wr(cal_ctrl_pkg::IDX_CTRL, 32'h00);
    poll(8'h02, 8'h00);
    check("bg resumed", 32'h1, {31'h0, bg_act});
    $display("test bg done");
  endtask

  task automatic t_master();
    wr(cal_ctrl_pkg::IDX_CFG_MAIN, 32'h00);
    wr(cal_ctrl_pkg::IDX_MASTER, 32'h00);
    repeat (3) @(posedge clk);
    check("run off", 32'h0, {31'h0, run});
    rchk("status held", cal_ctrl_pkg::IDX_STATUS, 32'h00);
    fg_seen = 1'b0;
    fgo_seen = 1'b0;
    wr(cal_ctrl_pkg::IDX_MASTER, 32'h01);
    poll(8'h01, 8'h01);
    check("fg skipped", 32'h0, {31'h0, fg_seen});
    check("run on", 32'h1, {31'h0, run});
    wr(cal_ctrl_pkg::IDX_MASTER, 32'h00);
    wr(cal_ctrl_pkg::IDX_CFG_MAIN, 32'h05);
    wr(cal_ctrl_pkg::IDX_MASTER, 32'h01);
    poll(8'h01, 8'h01);
    check("fg ran", 32'h1, {31'h0, fg_seen});
    check("fgos ran", 32'h1, {31'h0, fgo_seen});
    $display("test master done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fg_seen = 1'b0;
    fgo_seen = 1'b0;
    bad_count = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_done_irq();
    t_regs();
    t_park();
    t_bg();
    t_master();
    complete_run();
  end

  // Whole run needs under a thousand cycles; this allows 20000
  initial begin
    #200000;
    bad_count++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
